// ---- pkg/prx_pkg.sv ----
package prx_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 20;
    // module state vector width, one write-enable branch per flop
    localparam int STATE_W       = 4;
    localparam int CNT_W         = 4;
    // least spacing between write-enable arrival at two flops
    localparam int WREN_STEP_NS  = 40;
    // least time from last write-enable branch to startup done
    localparam int STARTUP_NS    = 200;
    // extra settling after startup done before module release
    localparam int EXTRA_HOLD_NS = 100;
    localparam logic [CNT_W-1:0] WREN_STEP_CYC =
        CNT_W'((WREN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STARTUP_CYC =
        CNT_W'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] EXTRA_HOLD_CYC =
        CNT_W'((EXTRA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;
    // module flop values after state restore
    localparam logic [STATE_W-1:0] STATE_INIT = 4'h0;
    localparam logic [STATE_W-1:0] STATE_ONE  = 4'h1;
    localparam logic [STATE_W-1:0] WREN_NONE  = 4'h0;
    localparam logic [STATE_W-1:0] WREN_ALL   = 4'hF;
    // value shown to static logic while decoupled
    localparam logic [STATE_W-1:0] SAFE_VALUE = 4'h0;

    typedef enum {
        PRX_CE_IDLE,
        PRX_CE_LOAD,
        PRX_CE_RESTORE,
        PRX_CE_WRITE_EN,
        PRX_CE_STARTUP
    } prx_ce_state_t;

    typedef enum {
        PRX_SC_RUN,
        PRX_SC_WAIT_LOW,
        PRX_SC_WAIT_DONE,
        PRX_SC_HOLD
    } prx_sc_state_t;
endpackage : prx_pkg

// ---- pkg/prx_if.sv ----
`timescale 1ns/10ps
interface prx_if;
    import prx_pkg::*;
    // configuration engine to region
    logic                      global_state_restore;
    logic [STATE_W-1:0]        global_write_enable;
    logic                      startup_done;
    // swappable module outputs
    logic [STATE_W-1:0]        module_data;
    logic                      module_valid;
    // static control to swappable module
    logic                      module_reset;
    logic                      module_reset_n;
    logic                      module_clk_en;
    logic                      module_ready;

    modport cfg (
        output global_state_restore,
        output global_write_enable,
        output startup_done,
        output module_data,
        output module_valid,
        input  module_reset,
        input  module_reset_n,
        input  module_clk_en,
        input  module_ready
    );

    modport ctrl (
        input  global_state_restore,
        input  global_write_enable,
        input  startup_done,
        input  module_data,
        input  module_valid,
        output module_reset,
        output module_reset_n,
        output module_clk_en,
        output module_ready
    );
endinterface : prx_if

// ---- design/prx_cfg_engine.sv ----
`timescale 1ns/10ps
module prx_cfg_engine
    import prx_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // load control
    input  wire logic i_load_start,
    input  wire logic i_image_loaded,
    input  wire logic i_target_self,
    output logic      o_busy,
    // region link
    prx_if.cfg        bus
);
    prx_ce_state_t         state;
    prx_ce_state_t         next_state;
    logic [CNT_W-1:0]      cnt;
    logic                  target;
    logic                  reset_seen;
    logic [STATE_W-1:0]    mstate;

    wire  start_ok   = (state == PRX_CE_IDLE) && i_load_start;
    wire  cnt_hit_gw = (cnt == WREN_STEP_CYC);
    wire  step_wrap  = (state == PRX_CE_WRITE_EN) && cnt_hit_gw;
    wire  cnt_hit_su = (cnt == STARTUP_CYC);
    wire  wren_full  = (bus.global_write_enable == WREN_ALL);
    wire  [STATE_W-1:0] wren_grow = {bus.global_write_enable[STATE_W-2:0], 1'b1};
    wire  [STATE_W-1:0] next_mstate = mstate + STATE_ONE;

    // restore, then write enable, then startup done
    always_comb begin
        next_state = state;
        case (state)
            PRX_CE_IDLE:     if (i_load_start) next_state = PRX_CE_LOAD;
            PRX_CE_LOAD:     if (i_image_loaded) begin
                                 next_state = target ? PRX_CE_RESTORE : PRX_CE_STARTUP;
                             end
            PRX_CE_RESTORE:  next_state = PRX_CE_WRITE_EN;
            PRX_CE_WRITE_EN: if (wren_full && cnt_hit_gw) next_state = PRX_CE_STARTUP;
            PRX_CE_STARTUP:  if (cnt_hit_su) next_state = PRX_CE_IDLE;
            default:         next_state = PRX_CE_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state  <= PRX_CE_IDLE;
            cnt    <= CNT_ZERO;
            target <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            state  <= next_state;
            // step wrap only while stepping, so startup count can reach its end
            cnt    <= (next_state != state || step_wrap) ? CNT_ZERO : cnt + CNT_ONE;
            if (start_ok) target <= i_target_self;
            o_busy <= (next_state != PRX_CE_IDLE);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.global_state_restore <= 1'b0;
            bus.global_write_enable  <= WREN_ALL;
            bus.startup_done         <= 1'b1;
        end else begin
            bus.global_state_restore <= (next_state == PRX_CE_RESTORE);
            // done drops for any region's load, not only ours
            bus.startup_done         <= (next_state == PRX_CE_IDLE);
            if (start_ok && i_target_self) begin
                bus.global_write_enable <= WREN_NONE;
            end else if (step_wrap) begin
                // skewed arrival, one flop branch per step
                bus.global_write_enable <= wren_grow;
            end
        end
    end

    // module flops each gated by their own write-enable branch
    genvar gi;
    generate
        for (gi = 0; gi < STATE_W; gi++) begin : g_flop
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    mstate[gi] <= STATE_INIT[gi];
                end else if (bus.global_state_restore) begin
                    mstate[gi] <= STATE_INIT[gi];
                end else if (bus.global_write_enable[gi]) begin
                    if (bus.module_reset) begin
                        mstate[gi] <= STATE_INIT[gi];
                    end else if (bus.module_clk_en && bus.module_ready) begin
                        mstate[gi] <= next_mstate[gi];
                    end
                end
            end
        end
    endgenerate

    // valid only once reset after the load has completed
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reset_seen       <= 1'b0;
            bus.module_valid <= 1'b0;
            bus.module_data  <= STATE_INIT;
        end else begin
            if (start_ok && i_target_self) begin
                reset_seen <= 1'b0;
            end else if (bus.startup_done && wren_full && bus.module_reset) begin
                reset_seen <= 1'b1;
            end
            bus.module_valid <= reset_seen && !bus.module_reset && bus.module_clk_en
                                && wren_full && !start_ok;
            bus.module_data  <= mstate;
        end
    end
endmodule : prx_cfg_engine

// ---- design/prx_static_ctrl.sv ----
`timescale 1ns/10ps
module prx_static_ctrl
    import prx_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    // region control
    input  wire logic               i_sys_reset,
    input  wire logic               i_load_req,
    input  wire logic               i_sw_mode,
    input  wire logic               i_sw_release,
    output logic                    o_decoupled,
    output logic                    o_module_loading_flag,
    // static user data
    input  wire logic               i_ready,
    output logic [STATE_W-1:0]      o_data,
    output logic                    o_valid,
    // region link
    prx_if.ctrl                     bus
);
    prx_sc_state_t         state;
    prx_sc_state_t         next_state;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      next_cnt;
    logic                  done_meta;
    logic                  done_sync;
    logic                  in_run;
    logic                  in_hold;
    logic                  load_taken;
    logic                  count_done;
    logic                  hold_over;
    logic                  next_flag;
    logic                  next_module_reset;
    logic                  next_clk_en;
    logic                  next_ready;
    logic                  capture_en;
    logic                  data_load;
    wire  [STATE_W-1:0]    sel_data;

    // startup done enters through two flops
    // only the second flop feeds the state machine
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            done_meta <= bus.startup_done;
            done_sync <= done_meta;
        end
    end

    // state decode
    assign in_run     = (state == PRX_SC_RUN);
    assign in_hold    = (state == PRX_SC_HOLD);
    // requests only taken while running
    assign load_taken = in_run && i_load_req;

    // settling count runs only while holding
    // wraps harmlessly in software release mode
    assign count_done = (cnt == EXTRA_HOLD_CYC);
    assign next_cnt   = (in_hold && next_state == PRX_SC_HOLD) ? cnt + CNT_ONE : CNT_ZERO;
    // software release or counted hold after done
    assign hold_over  = i_sw_mode ? i_sw_release : count_done;

    // done high before our load belongs to another region
    always_comb begin
        next_state = state;
        case (state)
            PRX_SC_RUN: begin
                if (load_taken) next_state = PRX_SC_WAIT_LOW;
            end
            PRX_SC_WAIT_LOW: begin
                if (!done_sync) next_state = PRX_SC_WAIT_DONE;
            end
            PRX_SC_WAIT_DONE: begin
                // nothing released before done
                if (done_sync) next_state = PRX_SC_HOLD;
            end
            PRX_SC_HOLD: begin
                if (hold_over) next_state = PRX_SC_RUN;
            end
            default: begin
                next_state = PRX_SC_RUN;
            end
        endcase
    end

    // next-cycle controls from the next state, plus i_sys_reset for reset and i_ready for ready
    // flag raised on request, cleared no earlier than done
    assign next_flag         = (next_state != PRX_SC_RUN);
    // region reset from own load or system reset
    assign next_module_reset = i_sys_reset | next_flag;
    // clock enable withheld until release
    assign next_clk_en       = ~next_flag;
    // handshake closed while module replaced
    assign next_ready        = ~next_flag & i_ready;

    // state and settling count
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= PRX_SC_RUN;
            cnt   <= CNT_ZERO;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // loading flag for the static side
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_module_loading_flag <= 1'b0;
        end else begin
            o_module_loading_flag <= next_flag;
        end
    end

    // isolation status
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_decoupled <= 1'b0;
        end else begin
            o_decoupled <= next_flag;
        end
    end

    // reset asserted on request, before write enable, held past done
    // reset held active for the whole decoupling
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.module_reset   <= 1'b1;
            bus.module_reset_n <= 1'b0;
        end else begin
            bus.module_reset   <= next_module_reset;
            // single inverted copy for active-low consumers
            bus.module_reset_n <= ~next_module_reset;
        end
    end

    // module clock enable
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.module_clk_en <= 1'b0;
        end else begin
            bus.module_clk_en <= next_clk_en;
        end
    end

    // module handshake
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.module_ready <= 1'b0;
        end else begin
            bus.module_ready <= next_ready;
        end
    end

    // register enable withheld while decoupled
    assign capture_en = !next_flag && !o_decoupled && bus.module_valid && bus.module_ready;
    // safe value loaded as soon as isolation starts
    assign data_load  = capture_en || next_flag;

    // per-bit selector substitutes safe value while decoupled
    genvar gi;
    generate
        for (gi = 0; gi < STATE_W; gi++) begin : g_iso
            assign sel_data[gi] = next_flag ? SAFE_VALUE[gi] : bus.module_data[gi];
        end
    endgenerate

    // captured data
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= SAFE_VALUE;
        end else begin
            if (data_load) o_data <= sel_data;
        end
    end

    // one valid pulse per captured word
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
        end else begin
            o_valid <= capture_en;
        end
    end
endmodule : prx_static_ctrl

// ---- bench/prx_props.sv ----
`timescale 1ns/10ps
module prx_props
    import prx_pkg::*;
(
    // clock and reset
    input wire logic               i_clk,
    input wire logic               i_nrst,
    // region link
    input wire logic               global_state_restore,
    input wire logic [STATE_W-1:0] global_write_enable,
    input wire logic               startup_done,
    input wire logic               module_reset,
    input wire logic               module_reset_n,
    input wire logic               module_clk_en,
    input wire logic               module_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_reset_n_inverse: assert property (module_reset_n == !module_reset)
        else $error("inverted reset copy differs");
    a_reset_before_wren: assert property (
        (global_write_enable & ~$past(global_write_enable)) != WREN_NONE |-> module_reset)
        else $error("write enable rose without module reset");
    a_release_after_done: assert property (
        $fell(module_reset) |-> startup_done && $past(startup_done, 2))
        else $error("reset released too early");
    a_reset_held_load: assert property (
        module_reset && !startup_done |=> module_reset)
        else $error("reset dropped before done");
    a_clk_en_done: assert property ($rose(module_clk_en) |-> startup_done)
        else $error("clock enable before done");
    a_clk_en_reset: assert property (!module_clk_en |-> module_reset)
        else $error("clock stopped without reset");
    a_ready_isolated: assert property (!module_clk_en |-> !module_ready)
        else $error("handshake open while isolated");
    a_restore_order: assert property (
        global_state_restore |=> !global_state_restore ##[1:3] global_write_enable[0])
        else $error("restore not followed by write enable");
    a_done_after_gwe: assert property (
        $rose(startup_done) |-> global_write_enable == WREN_ALL && !global_state_restore)
        else $error("done before all write enables");
endmodule : prx_props

// ---- bench/partial_reconfig_isolation_reset_tb.sv ----
`timescale 1ns/10ps
module partial_reconfig_isolation_reset_tb;
    import prx_pkg::*;
    logic               i_clk, i_nrst, load_start, image_loaded, target_self, busy;
    logic               sys_reset, load_req, sw_mode, sw_release, decoupled, flag, ready;
    logic               o_valid;
    logic [STATE_W-1:0] o_data;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 seed = 32'h69fba9fd;
    int                 n;

    prx_if bus ();
    prx_cfg_engine prx_cfg_engine_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_load_start(load_start), .i_image_loaded(image_loaded),
        .i_target_self(target_self), .o_busy(busy), .bus(bus));
    prx_static_ctrl prx_static_ctrl_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_sys_reset(sys_reset), .i_load_req(load_req), .i_sw_mode(sw_mode),
        .i_sw_release(sw_release), .o_decoupled(decoupled),
        .o_module_loading_flag(flag), .i_ready(ready), .o_data(o_data),
        .o_valid(o_valid), .bus(bus));
    prx_props prx_props_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .global_state_restore(bus.global_state_restore),
        .global_write_enable(bus.global_write_enable), .startup_done(bus.startup_done),
        .module_reset(bus.module_reset), .module_reset_n(bus.module_reset_n),
        .module_clk_en(bus.module_clk_en), .module_ready(bus.module_ready));

    initial begin
        i_clk = 1'b0;
        forever #(CLK_PERIOD_NS/2) i_clk = ~i_clk;
    end

    task automatic tick(input int k = 1);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic hold_ok(input logic sw, input int k);
        return sw ? (k <= 2) : (k >= int'(EXTRA_HOLD_CYC));
    endfunction : hold_ok

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic traffic(input int k);
        logic [3:0] exp;
        logic       cap;
        repeat (k) begin
            ready = 1'($random(seed));
            exp = bus.module_data;
            cap = bus.module_valid & bus.module_ready & ~decoupled;
            tick();
            check(o_valid, cap);
            if (cap) check(o_data, exp);
        end
    endtask : traffic

    task automatic do_load(input logic tgt, input logic sw);
        sw_mode = sw;
        if (tgt) begin
            load_req = 1'b1;
            tick();
            load_req = 1'b0;
            check(decoupled, 1'b1);
            check(flag, 1'b1);
            check(o_data, SAFE_VALUE);
            tick(3);
        end
        load_start = 1'b1;
        target_self = tgt;
        tick();
        load_start = 1'b0;
        tick(2 + $unsigned($random(seed)) % 8);
        image_loaded = 1'b1;
        tick();
        image_loaded = 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            check(bus.module_reset, tgt);
            check(o_valid & tgt, 1'b0);
            tick();
            n++;
        end
        if (tgt) begin
            n = 0;
            if (sw) begin
                tick(20);
                check(decoupled, 1'b1);
                sw_release = 1'b1;
            end
            while (decoupled === 1'b1 && n < 60) begin
                tick();
                n++;
            end
            sw_release = 1'b0;
            check(hold_ok(sw, n), 1'b1);
        end
        check(decoupled, 1'b0);
        check(bus.module_reset, 1'b0);
    endtask : do_load

    initial begin
        i_nrst = 1'b0;
        {load_start, image_loaded, target_self, sys_reset} = 4'h0;
        {load_req, sw_mode, sw_release, ready} = 4'h0;
        tick(10);
        i_nrst = 1'b1;
        tick(3);
        sys_reset = 1'b1;
        tick(2);
        check(bus.module_reset, 1'b1);
        check(bus.module_reset_n, 1'b0);
        sys_reset = 1'b0;
        tick(2);
        check(bus.module_reset, 1'b0);
        traffic(20);
        $display("test system reset finished");
        do_load(1'b1, 1'b0);
        traffic(30);
        $display("test counted hold finished");
        do_load(1'b1, 1'b1);
        traffic(30);
        $display("test software release finished");
        do_load(1'b0, 1'b0);
        traffic(30);
        $display("test other region finished");
        stop_test();
    end

    initial begin
        #(CLK_PERIOD_NS * 4000);
        mismatches++;
        stop_test();
    end
endmodule : partial_reconfig_isolation_reset_tb
